// ===== failsafe_pkg.sv
// Purpose: shared constants and types of the fail-safe status monitor
// Assumes: 8-bit registers behind the serial interface byte port
// Notes: reset values are those of the configuration registers after power-up
package failsafe_pkg;
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_MODULATION = 8'h05;
   localparam int NUM_CFG = 2;
   localparam int IDX_MODE = 0;
   localparam int IDX_MODULATION = 1;
   localparam logic [7:0] MODE_RESET = 8'h06;
   localparam logic [7:0] MODULATION_RESET = 8'h25;
   localparam int BIT_REQUEST = 7;
   localparam int BIT_PA_CUTOFF = 4;
   localparam int STATUS_BIT_ONE = 7;
   localparam int STATUS_BIT_LOWER = 5;
   localparam int STATUS_BIT_UPPER = 4;
   localparam int STATUS_BIT_BROWNOUT = 2;
   localparam int STATUS_BIT_PARITY = 1;
   localparam int STATUS_BIT_LOCK = 0;
   localparam logic BROWNOUT_RESET = 1'b1;
   // sleep wait count at which shutdown fires, three system clock cycles after en_fall
   localparam logic [1:0] SLEEP_LATENCY = 2'h2;

   // host-side register access, one byte per transfer
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_access_t;

   typedef struct packed {
      logic lower;
      logic upper;
      logic brownout;
      logic parity;
      logic lock;
   } flags_t;

   typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP_WAIT, ST_SLEEP} power_state_t;
endpackage

// ===== failsafe_status_monitor.sv
// Purpose: mode request bits, fail-safe flags, status register and PA cut-off
// Assumes: register access pulses come from the serial interface on sys_clk
// Notes: rst_n is the internal brownout/power-on reset, so the brownout flag resets to 1
`timescale 1ns/1ps
// How it works
// RULE1: standby request bit self-clears when accepted
// RULE2: sleep request; configuration lost after sleep
// RULE3: host sets sleep, drops enable; shutdown two cycles (code: shutdown fires three cycles after en_fall)
// RULE4: host sets standby bit, then drops enable
// RULE5: brownout resets device and sets flag
// RULE6: per-register parity stored, checked continuously
// RULE7: parity checking continues in standby
// RULE8: lock loss during transmission sets flag
// RULE9: error flags latch; cleared only by status read
// RULE10: cut-off enabled plus any flag disables PA
// RULE11: host reads status before and after transmission
// RULE12: upper battery flag lowers threshold; lower flag
// RULE13: battery flags clear at every transmission start
// RULE14: status layout: one, battery, brownout, parity, lock
// RULE15: battery flags invalid during standby
// RULE16: flag event during status read survives
module failsafe_status_monitor (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire failsafe_pkg::reg_access_t reg_access,
   input wire logic en_pin,
   input wire logic brownout_det,
   input wire logic pll_locked,
   input wire logic batt_below_upper,
   input wire logic batt_below_threshold,
   input wire logic tx_start,
   input wire logic tx_active,
   output logic [7:0] rd_data_reg,
   output logic standby_enter_reg,
   output logic sleep_shutdown_reg,
   output logic pa_disable_reg,
   output logic threshold_lower_reg,
   output failsafe_pkg::flags_t flags_reg
);
   import failsafe_pkg::*;

   logic [1:0] en_sync_reg, brown_sync_reg, lock_sync_reg, upper_sync_reg, thr_sync_reg;
   logic en_prev_reg;
   logic [7:0] cfg_reg [NUM_CFG];
   logic parity_reg [NUM_CFG];
   logic [NUM_CFG-1:0] parity_bad;
   logic [1:0] sleep_cnt_reg;
   power_state_t state_reg, state_next;
   flags_t flags_next;

   wire en_fall = en_prev_reg & ~en_sync_reg[1];
   wire wr_mode = reg_access.wr & (reg_access.addr == ADDR_MODE);
   wire wr_modulation = reg_access.wr & (reg_access.addr == ADDR_MODULATION);
   wire rd_status = reg_access.rd & (reg_access.addr == ADDR_STATUS);
   wire standby_pending = cfg_reg[IDX_MODE][BIT_REQUEST];
   wire sleep_pending = cfg_reg[IDX_MODULATION][BIT_REQUEST];
   wire cfg_wipe = (state_reg == ST_SLEEP_WAIT) & (sleep_cnt_reg == SLEEP_LATENCY);
   wire [NUM_CFG-1:0] cfg_wr = {wr_modulation, wr_mode};
   localparam logic [7:0] cfg_reset [NUM_CFG] = '{MODE_RESET, MODULATION_RESET};

   // RULE14 status layout
   wire [7:0] status_view = {1'b1, 1'b0, flags_reg.lower, flags_reg.upper, 1'b0,
                             flags_reg.brownout, flags_reg.parity, flags_reg.lock};
   wire [7:0] rd_mux = (reg_access.addr == ADDR_STATUS) ? status_view :
                       (reg_access.addr == ADDR_MODE) ? cfg_reg[IDX_MODE] :
                       (reg_access.addr == ADDR_MODULATION) ? cfg_reg[IDX_MODULATION] :
                       8'h00;

   // pins from the outside pass two flip-flops before use
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         en_sync_reg <= 2'h0;
         brown_sync_reg <= 2'h0;
         lock_sync_reg <= 2'h0;
         upper_sync_reg <= 2'h0;
         thr_sync_reg <= 2'h0;
         en_prev_reg <= 1'b0;
      end else begin
         en_sync_reg <= {en_sync_reg[0], en_pin};
         brown_sync_reg <= {brown_sync_reg[0], brownout_det};
         lock_sync_reg <= {lock_sync_reg[0], pll_locked};
         upper_sync_reg <= {upper_sync_reg[0], batt_below_upper};
         thr_sync_reg <= {thr_sync_reg[0], batt_below_threshold};
         en_prev_reg <= en_sync_reg[1];
      end
   end

   // one generate entry per configuration register with its parity bit
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               cfg_reg[gi] <= cfg_reset[gi];
               parity_reg[gi] <= ^cfg_reset[gi];
            end else if (cfg_wipe) begin
               // RULE2 contents lost
               cfg_reg[gi] <= cfg_reset[gi];
               parity_reg[gi] <= ^cfg_reset[gi];
            end else if (cfg_wr[gi]) begin
               // RULE6 parity on write
               cfg_reg[gi] <= reg_access.wdata;
               parity_reg[gi] <= ^reg_access.wdata;
            end else if (gi == IDX_MODE && en_fall && standby_pending) begin
               // RULE1 self-clear on accept
               cfg_reg[gi] <= {1'b0, cfg_reg[gi][6:0]};
               parity_reg[gi] <= ^{1'b0, cfg_reg[gi][6:0]};
            end
         end
         // RULE6 continuous check; RULE7 no mode gating, so it runs in standby too
         assign parity_bad[gi] = (^cfg_reg[gi]) != parity_reg[gi];
      end
   endgenerate

   // RULE3 sleep shutdown timing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_ACTIVE: begin
            if (en_fall && sleep_pending) begin
               state_next = ST_SLEEP_WAIT;
            end
         end
         ST_SLEEP_WAIT: begin
            if (cfg_wipe) begin
               state_next = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (en_sync_reg[1]) begin
               state_next = ST_ACTIVE;
            end
         end
         default: state_next = ST_ACTIVE;
      endcase
   end

   // RULE9 latch until read; RULE16 set beats read clear
   always_comb begin
      flags_next = flags_reg;
      if (rd_status) begin
         flags_next.brownout = 1'b0;
         flags_next.parity = 1'b0;
         flags_next.lock = 1'b0;
      end
      // RULE13 battery flags cleared
      if (tx_start) begin
         flags_next.upper = 1'b0;
         flags_next.lower = 1'b0;
      end
      // RULE5 brownout flag
      if (brown_sync_reg[1]) begin
         flags_next.brownout = 1'b1;
      end
      if (|parity_bad) begin
         flags_next.parity = 1'b1;
      end
      // RULE8 lock loss
      if (tx_active && !lock_sync_reg[1]) begin
         flags_next.lock = 1'b1;
      end
      // RULE12 two-step detector
      if (upper_sync_reg[1]) begin
         flags_next.upper = 1'b1;
      end
      // second step only while the upper flag survives this cycle, so a
      // transmission start clears both flags together
      // RULE15 no standby gating; host ignores these flags there
      if (flags_reg.upper && flags_next.upper && thr_sync_reg[1]) begin
         flags_next.lower = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= ST_ACTIVE;
         sleep_cnt_reg <= 2'h0;
         // RULE5 reset leaves the brownout flag set
         flags_reg <= '{lower: 1'b0, upper: 1'b0, brownout: BROWNOUT_RESET,
                        parity: 1'b0, lock: 1'b0};
         rd_data_reg <= 8'h00;
         standby_enter_reg <= 1'b0;
         sleep_shutdown_reg <= 1'b0;
         pa_disable_reg <= 1'b0;
         threshold_lower_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sleep_cnt_reg <= (state_reg == ST_SLEEP_WAIT) ? sleep_cnt_reg + 2'h1 : 2'h0;
         flags_reg <= flags_next;
         if (reg_access.rd) begin
            rd_data_reg <= rd_mux;
         end
         // RULE1 request accepted
         standby_enter_reg <= en_fall & standby_pending & ~sleep_pending;
         sleep_shutdown_reg <= cfg_wipe;
         // RULE10 PA cut-off
         pa_disable_reg <= cfg_reg[IDX_MODE][BIT_PA_CUTOFF] & (|flags_next);
         // RULE12 threshold follows upper flag
         threshold_lower_reg <= flags_next.upper;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence sleep_armed;
      en_fall && sleep_pending && state_reg == ST_ACTIVE;
   endsequence
   sequence shutdown_done;
      ##4 sleep_shutdown_reg ##1 (cfg_reg[IDX_MODULATION] == MODULATION_RESET);
   endsequence

   AST_STANDBY_CLEAR: assert property ( // RULE1
      en_fall && standby_pending && !cfg_wr[IDX_MODE] && !cfg_wipe
      |=> !cfg_reg[IDX_MODE][BIT_REQUEST] && standby_enter_reg == !sleep_pending)
      else $error("standby request did not self-clear");
   AST_SLEEP_SHUTDOWN: assert property (sleep_armed |-> shutdown_done) // RULE3
      else $error("sleep shutdown latency wrong");
   AST_CFG_LOST: assert property ( // RULE2
      sleep_shutdown_reg |-> cfg_reg[IDX_MODE] == MODE_RESET)
      else $error("configuration kept after sleep");
   AST_BROWNOUT_SET: assert property ( // RULE5
      brown_sync_reg[1] |=> flags_reg.brownout)
      else $error("brownout flag not set");
   AST_PARITY_SET: assert property ( // RULE6
      (|parity_bad) |=> flags_reg.parity)
      else $error("parity mismatch not flagged");
   AST_LOCK_SET: assert property ( // RULE8
      tx_active && !lock_sync_reg[1] |=> flags_reg.lock)
      else $error("lock loss not flagged");
   AST_LATCHED: assert property ( // RULE9
      flags_reg.lock && !rd_status |=> flags_reg.lock)
      else $error("lock flag dropped without read");
   AST_READ_CLEAR: assert property ( // RULE9
      rd_status && !brown_sync_reg[1] |=> !flags_reg.brownout)
      else $error("status read did not clear brownout");
   AST_PA_CUT: assert property ( // RULE10
      cfg_reg[IDX_MODE][BIT_PA_CUTOFF] && (|flags_reg) && !rd_status && !tx_start
      |=> pa_disable_reg)
      else $error("PA not cut off on error");
   AST_LOWER_NEEDS_UPPER: assert property ( // RULE12
      $rose(flags_reg.lower) |-> flags_reg.upper && threshold_lower_reg)
      else $error("lower battery flag without upper step");
   AST_TX_CLEAR: assert property ( // RULE13
      tx_start && !upper_sync_reg[1] |=> !flags_reg.upper && !flags_reg.lower)
      else $error("battery flags survive transmission start");
   AST_STATUS_READ: assert property ( // RULE14
      reg_access.rd && reg_access.addr == ADDR_STATUS |=> rd_data_reg[STATUS_BIT_ONE])
      else $error("status bit 7 not one");
endmodule

// ===== host_model.sv
// Purpose: host model driving the register byte port and the enable pin
// Assumes: requests change at the falling clock edge and last one cycle
// Notes: idle address and data are inverted so stale values are never trusted
`timescale 1ns/1ps
module host_model (
   input wire logic sys_clk,
   input wire logic [7:0] rd_data,
   output failsafe_pkg::reg_access_t reg_access,
   output logic en_pin
);
   import failsafe_pkg::*;
   initial begin
      reg_access = '0;
      en_pin = 1'b1;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(negedge sys_clk);
      reg_access = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge sys_clk);
      q = rd_data;
      reg_access = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic mode_req(input logic [7:0] a);
      logic [7:0] q;
      xfer(1'b1, a, 8'h80, q);
      @(negedge sys_clk);
      en_pin = 1'b0;
   endtask
   task automatic en_rise;
      @(negedge sys_clk);
      en_pin = 1'b1;
   endtask
endmodule

// ===== test_failsafe_status_monitor.sv
// Purpose: self-checking bench of the fail-safe status monitor
// Assumes: seeded random config bytes, hand-made fault events
// Notes: parity corruption cannot be injected from the ports
`timescale 1ns/1ps
module test_failsafe_status_monitor;
   import failsafe_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic brownout_det = 1'b0;
   logic pll_locked = 1'b1;
   logic batt_below_upper = 1'b0;
   logic batt_below_threshold = 1'b0;
   logic tx_start = 1'b0;
   logic tx_active = 1'b0;
   logic en_pin, standby_enter_reg, sleep_shutdown_reg, pa_disable_reg, threshold_lower_reg;
   logic [7:0] rd_data_reg, q, v;
   reg_access_t reg_access;
   flags_t flags_reg;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   host_model host_u (.sys_clk(sys_clk), .rd_data(rd_data_reg), .reg_access(reg_access),
      .en_pin(en_pin));
   failsafe_status_monitor dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_access(reg_access),
      .en_pin(en_pin), .brownout_det(brownout_det), .pll_locked(pll_locked),
      .batt_below_upper(batt_below_upper), .batt_below_threshold(batt_below_threshold),
      .tx_start(tx_start), .tx_active(tx_active), .rd_data_reg(rd_data_reg),
      .standby_enter_reg(standby_enter_reg), .sleep_shutdown_reg(sleep_shutdown_reg),
      .pa_disable_reg(pa_disable_reg), .threshold_lower_reg(threshold_lower_reg),
      .flags_reg(flags_reg));
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // well beyond the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      host_u.xfer(1'b0, a, 8'h00, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] t;
      host_u.xfer(1'b1, a, d, t);
   endtask
   task automatic wait_pulse(input string nm, input int k);
      logic s;
      s = 1'b0;
      for (int i = 0; i < 16 && s !== 1'b1; i++) begin
         @(negedge sys_clk);
         s = k ? sleep_shutdown_reg : standby_enter_reg;
      end
      chk(nm, 8'h01, {7'h00, s});
   endtask
   task automatic gap;
      repeat (6) @(negedge sys_clk);
   endtask
   initial begin
      v = 8'($urandom(76));
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      chk("flags", 8'h04, {3'h0, flags_reg});
      rd(ADDR_STATUS); chk("status", 8'h84, q);
      rd(ADDR_STATUS); chk("status", 8'h80, q);
      rd(ADDR_MODE); chk("mode", MODE_RESET, q);
      rd(ADDR_MODULATION); chk("modulation", MODULATION_RESET, q);
      rd(8'h02); chk("unmapped", 8'h00, q);
      $display("reset test done");
      repeat (20) begin
         v = 8'($urandom) & 8'h6F;
         wr(ADDR_MODE, v);
         wr(ADDR_MODULATION, v ^ 8'h7F);
         wr(ADDR_STATUS, ~v);
         rd(ADDR_MODE); chk("mode", v, q);
         rd(ADDR_MODULATION); chk("modulation", v ^ 8'h7F, q);
         rd(ADDR_STATUS); chk("status", 8'h80, q);
      end
      $display("random config test done");
      rd(ADDR_STATUS); chk("status", 8'h80, q);
      tx_start = 1'b1;
      tx_active = 1'b1;
      @(negedge sys_clk);
      tx_start = 1'b0;
      pll_locked = 1'b0;
      gap();
      pll_locked = 1'b1;
      gap();
      tx_active = 1'b0;
      chk("pa_disable", 8'h00, {7'h00, pa_disable_reg});
      rd(ADDR_STATUS); chk("status", 8'h81, q);
      rd(ADDR_STATUS); chk("status", 8'h80, q);
      $display("lock test done");
      wr(ADDR_MODE, 8'h16);
      brownout_det = 1'b1;
      gap();
      chk("pa_disable", 8'h01, {7'h00, pa_disable_reg});
      rd(ADDR_STATUS); chk("status", 8'h84, q);
      brownout_det = 1'b0;
      gap();
      rd(ADDR_STATUS); chk("status", 8'h84, q);
      rd(ADDR_STATUS); chk("status", 8'h80, q);
      gap();
      chk("pa_disable", 8'h00, {7'h00, pa_disable_reg});
      $display("brownout test done");
      batt_below_upper = 1'b1;
      gap();
      chk("threshold", 8'h01, {7'h00, threshold_lower_reg});
      chk("pa_disable", 8'h01, {7'h00, pa_disable_reg});
      rd(ADDR_STATUS); chk("status", 8'h90, q);
      batt_below_threshold = 1'b1;
      gap();
      rd(ADDR_STATUS); chk("status", 8'hB0, q);
      batt_below_upper = 1'b0;
      batt_below_threshold = 1'b0;
      gap();
      rd(ADDR_STATUS); chk("status", 8'hB0, q);
      chk("flags", 8'h18, {3'h0, flags_reg});
      tx_start = 1'b1;
      @(negedge sys_clk);
      tx_start = 1'b0;
      gap();
      rd(ADDR_STATUS); chk("status", 8'h80, q);
      $display("battery test done");
      host_u.mode_req(ADDR_MODE);
      wait_pulse("standby_enter", 0);
      host_u.en_rise();
      gap();
      rd(ADDR_MODE); chk("mode", 8'h00, q);
      $display("standby test done");
      host_u.mode_req(ADDR_MODULATION);
      wait_pulse("sleep_shutdown", 1);
      host_u.en_rise();
      gap();
      rd(ADDR_MODE); chk("mode", MODE_RESET, q);
      rd(ADDR_MODULATION); chk("modulation", MODULATION_RESET, q);
      $display("sleep test done");
      report_and_stop();
   end
endmodule
